// [lmf_regs.sv]
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
// Function
// - lane count code enables two to four lanes
// - byte 3 steered to selected lane, reset 3
// - byte 2 steered to selected lane, reset 2
// - byte 1 steered to selected lane, reset 1
// - byte 0 steered to selected lane, reset 0
// - negative wire state reported read-only
// - positive wire state reported read-only
module lmf_regs (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // cable wire sense, asynchronous
  input wire logic [1:0] neg_wire_fault_i,
  input wire logic [1:0] pos_wire_fault_i,
  // byte stream in
  input wire logic [3:0] byte_valid_i,
  input wire logic [31:0] byte_data_i,
  // lanes out
  output logic [3:0] lane_en_o,
  output logic [3:0] lane_valid_o,
  output logic [31:0] lane_data_o,
  // interrupt
  output logic irq_o
);
  logic [1:0] active_lane_count;
  logic [7:0] steering;
  logic [3:0] neg_s1, neg_s2;
  logic [1:0] neg_wire_fault;
  logic [1:0] pos_wire_fault;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [1:0] neg_prev;
  logic [1:0] pos_prev;
  logic [1:0] fault_event;

  wire wr_lane = wr_i && addr_i == lmf_pkg::OFS_LANE_COUNT;
  wire wr_steer = wr_i && addr_i == lmf_pkg::OFS_STEERING;
  wire wr_clear = wr_i && addr_i == lmf_pkg::OFS_IRQ_CLEAR;
  wire wr_enable = wr_i && addr_i == lmf_pkg::OFS_IRQ_ENABLE;
  wire [1:0] byte3_lane_select = steering[7:6];
  wire [1:0] byte2_lane_select = steering[5:4];
  wire [1:0] byte1_lane_select = steering[3:2];
  wire [1:0] byte0_lane_select = steering[1:0];

  // both wire codes share one two-stage synchroniser
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      neg_s1 <= {lmf_pkg::RST_WIRE_STATE, lmf_pkg::RST_WIRE_STATE};
      neg_s2 <= {lmf_pkg::RST_WIRE_STATE, lmf_pkg::RST_WIRE_STATE};
    end else if (ce_i) begin
      neg_s1 <= {neg_wire_fault_i, pos_wire_fault_i};
      neg_s2 <= neg_s1;
    end
  end
  assign neg_wire_fault = neg_s2[3:2];
  assign pos_wire_fault = neg_s2[1:0];

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_lane_count <= lmf_pkg::RST_LANE_COUNT;
      steering <= lmf_pkg::RST_STEERING;
    end else if (ce_i) begin
      if (wr_lane) begin
        active_lane_count <= wdata_i[lmf_pkg::LANE_COUNT_LSB +: 2];
      end
      if (wr_steer) begin
        steering <= wdata_i;
      end
    end
  end

  // a status bit sets whenever a wire code changes; irq_o fires only for bits set in irq_enable
  assign fault_event = {neg_wire_fault != neg_prev, pos_wire_fault != pos_prev};

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      neg_prev <= lmf_pkg::RST_WIRE_STATE;
      pos_prev <= lmf_pkg::RST_WIRE_STATE;
      irq_status <= 2'h0;
      irq_enable <= 2'h0;
    end else if (ce_i) begin
      neg_prev <= neg_wire_fault;
      pos_prev <= pos_wire_fault;
      // set wins over clear
      irq_status <= (irq_status & ~(wr_clear ? wdata_i[1:0] : 2'h0)) | fault_event;
      if (wr_enable) begin
        irq_enable <= wdata_i[1:0];
      end
    end
  end

  assign irq_o = |(irq_status & irq_enable);

  always_comb begin
    case (addr_i)
      lmf_pkg::OFS_LANE_COUNT:
        next_rdata = {2'h0, active_lane_count, lmf_pkg::RST_LANE_COUNT_LOW};
      lmf_pkg::OFS_STEERING:
        next_rdata = {byte3_lane_select, byte2_lane_select, byte1_lane_select,
          byte0_lane_select};
      lmf_pkg::OFS_RSVD_A: next_rdata = lmf_pkg::RST_RSVD_A;
      lmf_pkg::OFS_RSVD_B: next_rdata = lmf_pkg::RST_RSVD_B;
      lmf_pkg::OFS_RSVD_C: next_rdata = lmf_pkg::RST_RSVD_C;
      lmf_pkg::OFS_RSVD_D: next_rdata = lmf_pkg::RST_RSVD_D;
      lmf_pkg::OFS_RSVD_STAT_A, lmf_pkg::OFS_RSVD_STAT_B,
      lmf_pkg::OFS_RSVD_STAT_C, lmf_pkg::OFS_RSVD_STAT_D:
        next_rdata = lmf_pkg::RST_RSVD_STAT;
      lmf_pkg::OFS_WIRE_FAULT:
        next_rdata = {4'h0, neg_wire_fault, pos_wire_fault};
      lmf_pkg::OFS_IRQ_STATUS: next_rdata = {6'h0, irq_status};
      lmf_pkg::OFS_IRQ_ENABLE: next_rdata = {6'h0, irq_enable};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata <= 8'h00;
    end else if (ce_i) begin
      rdata <= rd_i ? next_rdata : 8'h00;
    end
  end
  assign rdata_o = rdata;

  lmf_lane_if lif ();
  assign lif.lane_count = active_lane_count;
  assign lif.steering = steering;
  assign lif.byte_valid = byte_valid_i;
  assign lif.byte_data = byte_data_i;
  assign lane_en_o = lif.lane_en;
  assign lane_valid_o = lif.lane_valid;
  assign lane_data_o = lif.lane_data;

  lmf_lane_mux u_mux (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .lif(lif)
  );

  lane_count_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    lane_en_o == (active_lane_count == 2'h3 ? 4'hf :
      active_lane_count == 2'h2 ? 4'h7 : 4'h3))
    else $error("lane enables do not follow count");
  steer_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && wr_steer |=> steering == $past(wdata_i))
    else $error("steering write lost");
  byte0_route_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && byte_valid_i == 4'h1 && lane_en_o[byte0_lane_select] |=>
      lane_valid_o[$past(byte0_lane_select)] &&
      lane_data_o[8*$past(byte0_lane_select) +: 8] == $past(byte_data_i[7:0]))
    else $error("byte 0 not on its lane");
  byte1_route_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && byte_valid_i == 4'h2 && lane_en_o[byte1_lane_select] |=>
      lane_valid_o == (4'h1 << $past(byte1_lane_select)))
    else $error("byte 1 not on its lane");
  byte2_route_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ce_i && byte_valid_i == 4'h4 && lane_en_o[byte2_lane_select] |=>
      lane_data_o[8*$past(byte2_lane_select) +: 8] == $past(byte_data_i[23:16]))
    else $error("byte 2 not on its lane");
  wire_report_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_i && addr_i == lmf_pkg::OFS_WIRE_FAULT && ce_i |=>
      rdata_o[3:2] == $past(neg_wire_fault) && rdata_o[7:4] == 4'h0)
    else $error("negative wire code misreported");
  pos_report_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_i && addr_i == lmf_pkg::OFS_WIRE_FAULT && ce_i |=>
      rdata_o[1:0] == $past(pos_wire_fault))
    else $error("positive wire code misreported");
  rsvd_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    rd_i && ce_i && addr_i == lmf_pkg::OFS_RSVD_B |=> rdata_o == 8'hc8)
    else $error("reserved default changed");
endmodule

// [lmf_pkg.sv]
package lmf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  // register offsets
  localparam logic [7:0] OFS_LANE_COUNT = 8'h65;
  localparam logic [7:0] OFS_STEERING = 8'h66;
  localparam logic [7:0] OFS_RSVD_A = 8'h67;
  localparam logic [7:0] OFS_RSVD_B = 8'h68;
  localparam logic [7:0] OFS_RSVD_C = 8'h69;
  localparam logic [7:0] OFS_RSVD_D = 8'h6a;
  localparam logic [7:0] OFS_RSVD_STAT_A = 8'h72;
  localparam logic [7:0] OFS_RSVD_STAT_B = 8'h73;
  localparam logic [7:0] OFS_RSVD_STAT_C = 8'h74;
  localparam logic [7:0] OFS_RSVD_STAT_D = 8'h75;
  localparam logic [7:0] OFS_WIRE_FAULT = 8'h76;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h90;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h91;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h92;
  // field positions
  localparam int LANE_COUNT_LSB = 4;
  localparam int NEG_FAULT_LSB = 2;
  localparam int POS_FAULT_LSB = 0;
  // reset values and interrupt bit positions
  localparam logic [1:0] RST_LANE_COUNT = 2'h1;
  localparam logic [3:0] RST_LANE_COUNT_LOW = 4'h7;
  localparam logic [7:0] RST_STEERING = 8'he4;
  localparam logic [7:0] RST_RSVD_A = 8'h00;
  localparam logic [7:0] RST_RSVD_B = 8'hc8;
  localparam logic [7:0] RST_RSVD_C = 8'h00;
  localparam logic [7:0] RST_RSVD_D = 8'h00;
  localparam logic [7:0] RST_RSVD_STAT = 8'h00;
  localparam logic [1:0] RST_WIRE_STATE = 2'h2;
  localparam logic [1:0] IRQ_NEG_BIT = 2'h1;
  localparam logic [1:0] IRQ_POS_BIT = 2'h0;
  // wire fault codes
  typedef enum logic [1:0] {
    LMF_SHORT_SUPPLY = 2'h0,
    LMF_SHORT_GROUND = 2'h1,
    LMF_NORMAL = 2'h2,
    LMF_OPEN = 2'h3
  } lmf_wire_t;
endpackage

// [lmf_lane_if.sv]
`timescale 1ns/1ns
interface lmf_lane_if;
  logic [1:0] lane_count;
  logic [7:0] steering;
  logic [3:0] byte_valid;
  logic [31:0] byte_data;
  logic [3:0] lane_en;
  logic [3:0] lane_valid;
  logic [31:0] lane_data;
  modport regs (output lane_count, steering, byte_valid, byte_data,
    input lane_en, lane_valid, lane_data);
  modport mux (input lane_count, steering, byte_valid, byte_data,
    output lane_en, lane_valid, lane_data);
endinterface

// [lmf_lane_mux.sv]
`timescale 1ns/1ns
module lmf_lane_mux (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // lane side
  lmf_lane_if.mux lif
);
  function automatic logic [3:0] lanes_on(input logic [1:0] cnt);
    case (cnt)
      2'h2: lanes_on = 4'h7;
      2'h3: lanes_on = 4'hf;
      default: lanes_on = 4'h3;
    endcase
  endfunction

  function automatic logic [1:0] sel(input logic [7:0] s, input int b);
    sel = s[2*b +: 2];
  endfunction

  logic [3:0] en_w;
  logic [3:0] next_valid;
  logic [31:0] next_data;
  logic [3:0] valid_q;
  logic [31:0] data_q;

  // code 00 is undefined; treated like the two-lane setting
  assign en_w = lanes_on(lif.lane_count);

  always_comb begin
    next_valid = 4'h0;
    next_data = 32'h0;
    // later byte positions win on a collision; software keeps the map one-to-one
    for (int b = 0; b < 4; b++) begin
      if (lif.byte_valid[b] && en_w[sel(lif.steering, b)]) begin
        next_valid[sel(lif.steering, b)] = 1'b1;
        next_data[8*sel(lif.steering, b) +: 8] = lif.byte_data[8*b +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 4'h0;
      data_q <= 32'h0;
    end else if (ce_i) begin
      valid_q <= next_valid;
      data_q <= next_data;
    end
  end

  assign lif.lane_en = en_w;
  assign lif.lane_valid = valid_q;
  assign lif.lane_data = data_q;

  lane_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (valid_q & ~$past(en_w)) == 4'h0)
    else $error("data on a disabled lane");
endmodule

// [lmf_rx_model.sv]
`timescale 1ns/1ns
module lmf_rx_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // lanes in
  input wire logic [3:0] lane_en_i,
  input wire logic [3:0] lane_valid_i,
  // tallies
  output logic stray_o,
  output logic [15:0] bytes_o
);
  // receiver counts bytes on every lane, and a byte on a lane that is not enabled also sets stray_o
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stray_o <= 1'b0;
      bytes_o <= 16'h0000;
    end else begin
      if ((lane_valid_i & ~lane_en_i) != 4'h0) stray_o <= 1'b1;
      bytes_o <= bytes_o + 16'($countones(lane_valid_i));
    end
  end
endmodule

// [lmf_regs_tb_top.sv]
`timescale 1ns/1ns
module lmf_regs_tb_top;
  logic sys_clk_i, rst_i, ce_i, wr_i, rd_i, irq_o, stray, lane_req, rd_d, lane_d;
  logic [7:0] addr_i, wdata_i, rdata_o, steer;
  logic [1:0] neg_i, pos_i, pn;
  logic [3:0] byte_valid_i, lane_en_o, lane_valid_o;
  logic [31:0] byte_data_i, lane_data_o;
  logic [15:0] rx_bytes;
  logic [35:0] e;
  logic [1:0] map [4];
  logic [7:0] rd_q [$];
  logic [35:0] lane_q [$];
  int errors, n_tests, cycles, n_exp;
  localparam logic [15:0] RST_TAB [11] = '{16'h6517, 16'h66e4, 16'h6700, 16'h68c8,
    16'h6900, 16'h6a00, 16'h7200, 16'h7300, 16'h7400, 16'h7500, 16'h760a};

  lmf_regs u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .neg_wire_fault_i(neg_i), .pos_wire_fault_i(pos_i), .byte_valid_i(byte_valid_i),
    .byte_data_i(byte_data_i), .lane_en_o(lane_en_o), .lane_valid_o(lane_valid_o),
    .lane_data_o(lane_data_o), .irq_o(irq_o));
  lmf_rx_model u_rx (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .lane_en_i(lane_en_o),
    .lane_valid_i(lane_valid_o), .stray_o(stray), .bytes_o(rx_bytes));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    rd_q.push_back(exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask

  // one-to-one map so no two bytes fight over a lane
  task automatic new_map();
    int j;
    logic [1:0] t;
    for (int i = 0; i < 4; i++) map[i] = 2'(i);
    for (int i = 3; i > 0; i--) begin
      j = $urandom_range(i);
      t = map[i];
      map[i] = map[j];
      map[j] = t;
    end
    steer = {map[3], map[2], map[1], map[0]};
    wr(8'h66, steer);
    rd(8'h66, steer);
  endtask

  // code 00 acts as two lanes, so lane limit is at least 1
  task automatic send(input logic [1:0] c);
    logic [3:0] v, ev;
    logic [31:0] d, ed;
    v = 4'($urandom);
    d = $urandom;
    ev = 4'h0;
    ed = 32'h0;
    for (int b = 0; b < 4; b++) begin
      if (v[b] && map[b] <= ((c == 2'h0) ? 2'h1 : c)) begin
        ev[map[b]] = 1'b1;
        ed[8*map[b] +: 8] = d[8*b +: 8];
        n_exp++;
      end
    end
    @(posedge sys_clk_i);
    byte_valid_i <= v;
    byte_data_i <= d;
    lane_req <= 1'b1;
    lane_q.push_back({ev, ed});
  endtask

  always @(posedge sys_clk_i) begin
    rd_d <= rd_i;
    lane_d <= lane_req;
    if (rd_d) chk("rdata", rdata_o, rd_q.pop_front());
    if (lane_d) begin
      e = lane_q.pop_front();
      chk("lane_valid", lane_valid_o, e[35:32]);
      chk("lane_data", lane_data_o & {{8{e[35]}}, {8{e[34]}}, {8{e[33]}}, {8{e[32]}}},
        e[31:0]);
    end
    cycles++;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(67404));
    {rst_i, ce_i, wr_i, rd_i, lane_req, rd_d, lane_d} = 7'h60;
    {addr_i, wdata_i, byte_valid_i, byte_data_i} = '0;
    neg_i = 2'h2;
    pos_i = 2'h2;
    {errors, n_tests, cycles, n_exp} = '0;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk("lane_en", lane_en_o, 4'h3);
    for (int p = 0; p < 2; p++) begin
      foreach (RST_TAB[i]) rd(RST_TAB[i][15:8], RST_TAB[i][7:0]);
      for (int i = 2; i < 11; i++) wr(RST_TAB[i][15:8], 8'($urandom));
    end
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(8'h65, 8'(c << 4));
      rd(8'h65, 8'(c << 4) | 8'h07);
      chk("lane_en", lane_en_o, (c == 3) ? 4'hf : (c == 2) ? 4'h7 : 4'h3);
      new_map();
      repeat (20) send(2'(c));
      @(posedge sys_clk_i);
      lane_req <= 1'b0;
      byte_valid_i <= 4'h0;
    end
    wr(8'h92, 8'h03);
    wr(8'h91, 8'h03);
    for (int k = 0; k < 6; k++) begin
      if (k == 3) wr(8'h92, 8'h00);
      pn = neg_i;
      @(posedge sys_clk_i);
      neg_i <= 2'($urandom);
      pos_i <= 2'(k);
      repeat (4) @(posedge sys_clk_i);
      rd(8'h76, {4'h0, neg_i, pos_i});
      rd(8'h90, {6'h0, neg_i != pn, 1'b1});
      chk("irq", irq_o, 1'(k < 3));
      wr(8'h91, 8'h03);
      rd(8'h90, 8'h00);
      chk("irq", irq_o, 1'b0);
    end
    // a write while the clock enable is low must not land
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    wr(8'h66, ~steer);
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    rd(8'h66, steer);
    chk("rx_bytes", rx_bytes, 36'(n_exp));
    chk("stray", stray, 1'b0);
    give_verdict();
  end
endmodule
